// [hw/clock_gate_map.vh]
`ifndef CLOCK_GATE_MAP_VH
`define CLOCK_GATE_MAP_VH
// register byte offsets inside the system control space
`define SYSCTL_BASE 32'h400FE000
`define OFF_RUN_GATE 12'h100
`define OFF_SLEEP_GATE 12'h110
`define OFF_DEEP_GATE 12'h120
`define OFF_RUN_CFG 12'h060
`define OFF_IRQ_STATUS 12'h200
`define OFF_IRQ_MASK 12'h204
`define OFF_MODE_STATUS 12'h208
// field positions
`define BIT_WATCHDOG 3
`define BIT_AUTO_GATE 27
`define BIT_IRQ_FAULT 0
`define BIT_IRQ_MODE 1
// reset values and write masks
`define GATE_RESET 32'h00000040
`define GATE_WMASK 32'h00000008
`define RUN_CFG_RESET 32'h00000000
`define RUN_CFG_WMASK 32'h08000000
`define IRQ_WMASK 32'h00000003
// power modes
`define MODE_RUN 2'h0
`define MODE_SLEEP 2'h1
`define MODE_DEEP 2'h2
// enable settle hold after a mode change, in cycles
`define SETTLE_CYCLES 2
`endif

// [hw/watchdog_clock_gate.v]
`timescale 1ns/100ps
// glitch-free clock gate for the watchdog unit, enable captured on the falling edge
module watchdog_clock_gate (
    // clock in
    input wire sys_clk,
    // enable, synchronous to sys_clk
    input wire gate_en,
    // gated clock out
    output wire gated_clk
);
    // enable copy that only moves while the clock is low
    reg en_ff;

    // falling-edge capture: a late enable cannot cut a high phase short
    // costs half a cycle of latency, but needs no latch
    always @(negedge sys_clk) begin
        en_ff <= gate_en;
    end

    assign gated_clk = sys_clk & en_ff;
endmodule

// [hw/low_power_clock_gating.v]
// Functional notes
// RULE1: bit one feeds the unit its clock
// RULE2: bit zero stops the unit clock
// RULE3: access to gated unit returns bus fault
// RULE4: gating bits reset to zero
// RULE5: register chosen by run, sleep, deep mode
// RULE6: low-power registers used only with auto gating
// RULE7: bit 3 is watchdog enable, resets zero
// RULE8: software must enable needed units itself
// RULE9: software preserves reserved bits on updates
// RULE10: sleep at 0x110, deep sleep at 0x120
// RULE11: run gate register at 0x100
// RULE12: reserved bits read-only, bit 6 reads one
// RULE13: mode selection changes the enable glitch-free
`timescale 1ns/100ps
`include "clock_gate_map.vh"
module low_power_clock_gating (
    // clock and reset
    input wire sys_clk,
    input wire reset_n,
    // axi4-lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // power mode request from the power controller
    input wire sleep_req,
    input wire deep_sleep_req,
    // watchdog unit access qualifier from the peripheral bus
    input wire watchdog_access,
    output wire watchdog_bus_fault,
    // watchdog unit clock
    output wire watchdog_clk,
    output wire watchdog_clk_en,
    // interrupt
    output wire irq
);
    localparam RESP_OKAY = 2'h0;
    localparam RESP_SLVERR = 2'h2;

    // write one item of 32 bits under byte strobes, keeping read-only bits
    function [31:0] merge_write;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] strb;
        input [31:0] wmask;
        integer i;
        reg [31:0] lane;
        begin
            lane = 32'h00000000;
            for (i = 0; i < 4; i = i + 1) begin
                lane[i*8 +: 8] = {8{strb[i]}};
            end
            merge_write = (old_val & ~(lane & wmask)) | (new_val & lane & wmask);
        end
    endfunction

    // register file
    reg [31:0] run_gate_ff;        // run_clock_gate_0
    reg [31:0] sleep_gate_ff;      // sleep_clock_gate_0
    reg [31:0] deep_gate_ff;       // deep_sleep_clock_gate_0
    reg [31:0] run_cfg_ff;         // run_clock_config, auto_gating_select only
    reg [1:0] irq_status_ff;       // sticky events
    reg [1:0] irq_mask_ff;         // interrupt enables

    // bus handshake state
    reg aw_held_ff;                // write address captured
    reg w_held_ff;                 // write data captured
    reg [11:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    reg rvalid_ff;
    reg [31:0] rdata_ff;
    reg [1:0] rresp_ff;

    // mode pipeline: three flops for the external mode pins
    reg [1:0] sleep_sync_ff;
    reg [1:0] deep_sync_ff;
    reg [1:0] sleep_meta_ff;
    reg [1:0] mode_ff;
    reg [1:0] settle_ff;
    reg gate_en_ff;
    reg fault_ff;

    // handshake outputs: accept when not already holding that half; write halves also wait while a write response is pending
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    // both halves present this cycle, either freshly or held
    wire aw_have = aw_held_ff || aw_fire;
    wire w_have = w_held_ff || w_fire;
    wire wr_do = aw_have && w_have && !bvalid_ff;
    wire [11:0] wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
    wire [31:0] wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
    wire [3:0] wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;

    // address hit test shared by read and write decode
    function addr_hit;
        input [11:0] addr;
        begin
            addr_hit = (addr == `OFF_RUN_GATE) || (addr == `OFF_SLEEP_GATE) ||
                (addr == `OFF_DEEP_GATE) || (addr == `OFF_RUN_CFG) ||
                (addr == `OFF_IRQ_STATUS) || (addr == `OFF_IRQ_MASK) ||
                (addr == `OFF_MODE_STATUS);
        end
    endfunction

    // event pulses
    wire mode_change = (mode_ff != settle_ff);
    wire fault_evt = watchdog_access && !gate_en_ff;
    reg [1:0] nxt_irq_status;

    // sticky status: set wins over write-one-to-clear
    always @* begin
        nxt_irq_status = irq_status_ff;
        if (wr_do && wr_addr == `OFF_IRQ_STATUS && wr_strb[0]) begin
            nxt_irq_status = irq_status_ff & ~wr_data[1:0];
        end
        if (fault_evt) begin
            nxt_irq_status[`BIT_IRQ_FAULT] = 1'b1;
        end
        if (mode_change) begin
            nxt_irq_status[`BIT_IRQ_MODE] = 1'b1;
        end
    end

    // write channel and register updates
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            run_gate_ff <= `GATE_RESET;     // [RULE4]
            sleep_gate_ff <= `GATE_RESET;   // [RULE4]
            deep_gate_ff <= `GATE_RESET;    // [RULE4]
            run_cfg_ff <= `RUN_CFG_RESET;
            irq_status_ff <= 2'h0;
            irq_mask_ff <= 2'h0;
        end else begin
            irq_status_ff <= nxt_irq_status;
            // hold an early half until its partner shows up
            if (aw_fire && !wr_do) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_fire && !wr_do) begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= addr_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
                // in the gate registers only the watchdog bit is writable, reserved bits kept [RULE12]
                case (wr_addr)
                    `OFF_RUN_GATE: begin
                        run_gate_ff <= merge_write(run_gate_ff, wr_data, wr_strb,
                            `GATE_WMASK);                              // [RULE11]
                    end
                    `OFF_SLEEP_GATE: begin
                        sleep_gate_ff <= merge_write(sleep_gate_ff, wr_data, wr_strb,
                            `GATE_WMASK);                              // [RULE10] [RULE7]
                    end
                    `OFF_DEEP_GATE: begin
                        deep_gate_ff <= merge_write(deep_gate_ff, wr_data, wr_strb,
                            `GATE_WMASK);                              // [RULE10] [RULE7]
                    end
                    `OFF_RUN_CFG: begin
                        run_cfg_ff <= merge_write(run_cfg_ff, wr_data, wr_strb,
                            `RUN_CFG_WMASK);
                    end
                    `OFF_IRQ_MASK: begin
                        if (wr_strb[0]) begin
                            irq_mask_ff <= wr_data[1:0];
                        end
                    end
                    // status clears handled above, others have no effect
                    default: begin
                    end
                endcase
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // read channel: one cycle after the address is taken
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                `OFF_RUN_GATE: rdata_ff <= run_gate_ff;      // [RULE11]
                `OFF_SLEEP_GATE: rdata_ff <= sleep_gate_ff;  // [RULE10] [RULE12]
                `OFF_DEEP_GATE: rdata_ff <= deep_gate_ff;    // [RULE10] [RULE12]
                `OFF_RUN_CFG: rdata_ff <= run_cfg_ff;
                `OFF_IRQ_STATUS: rdata_ff <= {30'h00000000, irq_status_ff};
                `OFF_IRQ_MASK: rdata_ff <= {30'h00000000, irq_mask_ff};
                `OFF_MODE_STATUS: rdata_ff <= {29'h00000000, gate_en_ff, mode_ff};
                // unmapped reads return zero with an error response
                default: rdata_ff <= 32'h00000000;
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // mode pins come from the power controller domain: three flops, agree on 2nd/3rd
    reg [1:0] nxt_mode;
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            sleep_meta_ff <= 2'h0;
            sleep_sync_ff <= 2'h0;
            deep_sync_ff <= 2'h0;
        end else begin
            sleep_meta_ff <= {deep_sleep_req, sleep_req};
            sleep_sync_ff <= sleep_meta_ff;
            deep_sync_ff <= sleep_sync_ff;
        end
    end

    // decode mode; deep sleep outranks sleep
    always @* begin
        nxt_mode = mode_ff;
        if (sleep_sync_ff == deep_sync_ff) begin
            if (deep_sync_ff[1]) begin
                nxt_mode = `MODE_DEEP;
            end else if (deep_sync_ff[0]) begin
                nxt_mode = `MODE_SLEEP;
            end else begin
                nxt_mode = `MODE_RUN;
            end
        end
    end

    // select the register of the current mode for the watchdog enable
    reg nxt_gate_en;
    always @* begin
        case (mode_ff)
            `MODE_SLEEP: nxt_gate_en = run_cfg_ff[`BIT_AUTO_GATE] ?
                sleep_gate_ff[`BIT_WATCHDOG] : run_gate_ff[`BIT_WATCHDOG]; // [RULE5] [RULE6]
            `MODE_DEEP: nxt_gate_en = run_cfg_ff[`BIT_AUTO_GATE] ?
                deep_gate_ff[`BIT_WATCHDOG] : run_gate_ff[`BIT_WATCHDOG];  // [RULE5] [RULE6]
            default: nxt_gate_en = run_gate_ff[`BIT_WATCHDOG];           // [RULE5]
        endcase
    end

    // registered enable and fault; enable from a flop so the gate sees no hazard
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            mode_ff <= `MODE_RUN;
            settle_ff <= `MODE_RUN;
            gate_en_ff <= 1'b0;                                          // [RULE4]
            fault_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            settle_ff <= mode_ff;
            gate_en_ff <= nxt_gate_en;                                   // [RULE13]
            fault_ff <= fault_evt;                                       // [RULE3]
        end
    end

    // clock gate cell; falling-edge flop keeps a mode switch from chopping a pulse
    watchdog_clock_gate u_gate (
        .sys_clk(sys_clk),
        .gate_en(gate_en_ff),
        .gated_clk(watchdog_clk)                                         // [RULE1] [RULE2]
    );

    assign watchdog_clk_en = gate_en_ff;
    assign watchdog_bus_fault = fault_ff;                               // [RULE3]
    assign irq = |(irq_status_ff & irq_mask_ff);
endmodule

// [verif/low_power_clock_gating_sva.sv]
`timescale 1ns/100ps
// bus handshakes and watchdog fault timing seen at the block's ports
module low_power_clock_gating_sva (
    // clock and reset
    input wire sys_clk,
    input wire reset_n,
    // register bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // watchdog side
    input wire watchdog_access,
    input wire watchdog_bus_fault,
    input wire watchdog_clk_en
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // both write halves handed over in one cycle
    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // unit touched while its clock is withheld
    sequence access_gated;
        watchdog_access && !watchdog_clk_en;
    endsequence
    a_write_answer: assert property (write_taken |=> s_axi_bvalid)
        else $error("write got no response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read got no data");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_fault_gated: assert property (access_gated |=> watchdog_bus_fault)
        else $error("gated access gave no fault");
    a_fault_clocked: assert property (watchdog_access && watchdog_clk_en |=> !watchdog_bus_fault)
        else $error("fault while clock enabled");
    a_fault_cause: assert property (watchdog_bus_fault |-> $past(watchdog_access) && !$past(watchdog_clk_en))
        else $error("fault without gated access");
endmodule

bind low_power_clock_gating low_power_clock_gating_sva low_power_clock_gating_sva_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .watchdog_access(watchdog_access),
    .watchdog_bus_fault(watchdog_bus_fault), .watchdog_clk_en(watchdog_clk_en));

// [verif/cpu_bus_model.sv]
`timescale 1ns/100ps
// processor software as bus master: one write and one read at a time
module cpu_bus_model (
    // clock
    input wire sys_clk,
    // write address and data
    output logic [11:0] awaddr = 12'h000,
    output logic awvalid = 1'b0,
    input wire awready,
    output logic [31:0] wdata = 32'h00000000,
    output logic [3:0] wstrb = 4'hF,
    output logic wvalid = 1'b0,
    input wire wready,
    // write response
    input wire bvalid,
    output logic bready = 1'b0,
    // read channels
    output logic [11:0] araddr = 12'h000,
    output logic arvalid = 1'b0,
    input wire arready,
    input wire rvalid,
    output logic rready = 1'b0
);
    // whole-word write; released lines show the inverse so stale values never look valid
    task bus_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end while (!(bvalid && bready));
        bready <= 1'b0;
    endtask
    // read; the data itself is judged by the bench's watcher
    task bus_read(input logic [11:0] a);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
        end while (!(rvalid && rready));
        rready <= 1'b0;
    endtask
endmodule

// [verif/test_low_power_clock_gating.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin num_errors++; \
    $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module test_low_power_clock_gating;
    // stimulus driven by the bench
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic sleep_req = 1'b0;
    logic deep_sleep_req = 1'b0;
    logic watchdog_access = 1'b0;
    // bus wires between software model and block
    wire [11:0] awaddr, araddr;
    wire [31:0] wdata, rdata;
    wire [3:0] wstrb;
    wire [1:0] bresp, rresp;
    wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    wire watchdog_bus_fault, watchdog_clk, watchdog_clk_en, irq;
    // bookkeeping
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int wd_cnt = 0;
    int cnt0;
    logic [33:0] er;
    logic [1:0] eb;
    logic [31:0] seed = 32'h0000381B;
    logic [33:0] exp_r[$];
    logic [1:0] exp_b[$];
    low_power_clock_gating low_power_clock_gating_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
        .watchdog_access(watchdog_access), .watchdog_bus_fault(watchdog_bus_fault),
        .watchdog_clk(watchdog_clk), .watchdog_clk_en(watchdog_clk_en), .irq(irq));
    cpu_bus_model cpu_bus_model_i (.sys_clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rvalid(rvalid), .rready(rready));
    // 50 ns clock
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // edges actually delivered to the watchdog unit
    always @(posedge watchdog_clk) wd_cnt++;
    // hang guard, far above the roughly 110 cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            print_verdict();
        end
    end
    // watcher: oldest note against each response that appears
    always @(posedge sys_clk) begin
        if (rvalid && rready) begin
            er = exp_r.pop_front();
            `CHK("read", er, {rresp, rdata})
        end
        if (bvalid && bready) begin
            eb = exp_b.pop_front();
            `CHK("bresp", eb, bresp)
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task rd(input logic [11:0] a, input logic [1:0] r, input logic [31:0] d);
        exp_r.push_back({r, d});
        cpu_bus_model_i.bus_read(a);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_b.push_back(r);
        cpu_bus_model_i.bus_write(a, d);
    endtask
    // one-cycle access aimed at the watchdog unit, then mode sync time
    // fault stands one cycle, one edge after the access is sampled
    task poke_settle(input logic f);
        watchdog_access <= 1'b1;
        @(posedge sys_clk);
        watchdog_access <= 1'b0;
        @(posedge sys_clk);
        `CHK("bus fault", f, watchdog_bus_fault)
        `CHK("clk enable", !f, watchdog_clk_en)
        repeat (5) @(posedge sys_clk);
    endtask
    task print_verdict;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        logic [31:0] v;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(12'h110, 2'h0, 32'h00000040);
        rd(12'h120, 2'h0, 32'h00000040);
        rd(12'h100, 2'h0, 32'h00000040);
        rd(12'h300, 2'h2, 32'h00000000);
        wr(12'h300, 32'hFFFFFFFF, 2'h2);
        // only the watchdog bit takes random data
        for (int i = 0; i < 4; i++) begin
            v = xs();
            wr(12'h110, v, 2'h0);
            rd(12'h110, 2'h0, 32'h00000040 | (v & 32'h00000008));
        end
        wr(12'h120, 32'hFFFFFFFF, 2'h0);
        rd(12'h120, 2'h0, 32'h00000048);
        wr(12'h120, 32'h00000000, 2'h0);
        // read-modify-write style update: reserved bit 6 written back as read
        wr(12'h110, 32'h00000048, 2'h0);
        // sleep without auto gating keeps the run register in charge
        sleep_req <= 1'b1;
        cnt0 = wd_cnt;
        poke_settle(1'b1);
        `CHK("run gate in sleep", cnt0, wd_cnt)
        rd(12'h208, 2'h0, 32'h00000001);
        wr(12'h060, 32'h08000000, 2'h0);
        cnt0 = wd_cnt;
        poke_settle(1'b0);
        rd(12'h208, 2'h0, 32'h00000005);
        `CHK("sleep clock", 1'b1, wd_cnt > cnt0)
        deep_sleep_req <= 1'b1;
        repeat (6) @(posedge sys_clk);
        cnt0 = wd_cnt;
        poke_settle(1'b1);
        `CHK("deep clock", cnt0, wd_cnt)
        rd(12'h208, 2'h0, 32'h00000002);
        rd(12'h200, 2'h0, 32'h00000003);
        wr(12'h204, 32'h00000001, 2'h0);
        `CHK("irq", 1'b1, irq)
        wr(12'h200, 32'h00000003, 2'h0);
        `CHK("irq", 1'b0, irq)
        rd(12'h200, 2'h0, 32'h00000000);
        print_verdict();
    end
endmodule
